// ### rtl/acs_top.sv
// Converter sequencer with APB registers and shared port pin control.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
module acs_top
  import acs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic stop_mode,
  input wire logic crystal_reference_clock,
  input wire logic comparator_in,
  input wire logic [NUM_CH-1:0] port_pin_in,
  output logic [NUM_CH-1:0] port_pin_out,
  output logic [NUM_CH-1:0] port_pin_oe,
  output logic [4:0] selected_analog_input,
  output logic converter_power,
  output logic [7:0] dac_code,
  output logic conversion_irq
);
  acs_conv_if cif();

  logic [1:0] xclk_sync;
  logic xclk_prev;
  logic [1:0] comp_sync;
  logic [NUM_CH-1:0] pin_meta;
  logic [NUM_CH-1:0] pin_sync;
  logic [4:0] channel_select_field;
  logic done_irq_enable;
  logic continuous_convert_bit;
  logic conversion_done_flag;
  logic [7:0] result;
  logic [2:0] converter_clock_prescale;
  logic converter_clock_select_reg;
  logic [NUM_CH-1:0] port_data;
  logic [NUM_CH-1:0] port_dir;
  acs_state_e state;
  acs_state_e next_state;
  logic [3:0] tick_cnt;
  logic [7:0] sar;
  logic stop_q;
  logic [4:0] ticks_seen;

  function automatic logic [NUM_CH-1:0] chan_onehot(input logic [4:0] ch);
    logic [NUM_CH-1:0] v;
    v = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      if (ch == 5'(i)) begin
        v[i] = 1'b1;
      end
    end
    return v;
  endfunction : chan_onehot

  // Keep the trial bit when the input is at or above it, then try the next.
  function automatic logic [7:0] sar_step(input logic [7:0] code, input logic [3:0] cnt,
                                          input logic keep);
    logic [2:0] b;
    logic [7:0] r;
    b = 3'(LAST_TICK - cnt);
    r = keep ? code : code & ~(8'h01 << b);
    if (b != 3'h0) begin
      r = r | (8'h01 << (b - 3'h1));
    end
    return r;
  endfunction : sar_step

  // Bus access decode.
  logic apb_done;
  logic wr_en;
  logic rd_en;
  logic wr_status;
  logic wr_clkcfg;
  logic wr_pdata;
  logic wr_pdir;
  logic rd_result;
  logic addr_hit;
  logic [NUM_CH-1:0] chan_sel;
  logic [NUM_CH-1:0] pin_read;
  logic [7:0] status_read;
  logic [31:0] rd_word;

  assign apb_done = psel & penable & pready;
  assign wr_en = apb_done & pwrite;
  assign rd_en = apb_done & ~pwrite;
  assign wr_status = wr_en & (paddr == ADDR_STATUS);
  assign wr_clkcfg = wr_en & (paddr == ADDR_CLKCFG);
  assign wr_pdata = wr_en & (paddr == ADDR_PORT_DATA);
  assign wr_pdir = wr_en & (paddr == ADDR_PORT_DIR);
  assign rd_result = rd_en & (paddr == ADDR_RESULT);
  assign addr_hit = (paddr == ADDR_STATUS) | (paddr == ADDR_RESULT) |
                    (paddr == ADDR_CLKCFG) | (paddr == ADDR_PORT_DATA) |
                    (paddr == ADDR_PORT_DIR) | (paddr == ADDR_PORT_PIN);

  assign chan_sel = chan_onehot(channel_select_field);
  // A pin taken by the converter reads as its latch when output, else zero.
  assign pin_read = (port_dir & port_data) | (~port_dir & ~chan_sel & pin_sync);
  assign status_read = {conversion_done_flag & ~done_irq_enable, done_irq_enable,
                        continuous_convert_bit, channel_select_field};
  assign rd_word = (paddr == ADDR_STATUS) ? {24'h0, status_read} :
                   (paddr == ADDR_RESULT) ? {24'h0, result} :
                   (paddr == ADDR_CLKCFG) ? {24'h0, converter_clock_prescale,
                                             converter_clock_select_reg, 4'h0} :
                   (paddr == ADDR_PORT_DATA) ? {20'h0, port_data} :
                   (paddr == ADDR_PORT_DIR) ? {20'h0, port_dir} :
                   (paddr == ADDR_PORT_PIN) ? {20'h0, pin_read} : 32'h0;

  // One wait state, so read data and the answer both come from flip-flops.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~addr_hit;
      prdata <= (psel & penable & ~pready) ? rd_word : 32'h0;
    end
  end

  // Input synchronisers for the crystal clock, comparator and pins.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      xclk_sync <= 2'h0;
      xclk_prev <= 1'b0;
      comp_sync <= 2'h0;
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      xclk_sync <= {xclk_sync[0], crystal_reference_clock};
      xclk_prev <= xclk_sync[1];
      comp_sync <= {comp_sync[0], comparator_in};
      pin_meta <= port_pin_in;
      pin_sync <= pin_meta;
    end
  end

  assign cif.src_tick = converter_clock_select_reg ? 1'b1 : (xclk_sync[1] & ~xclk_prev);
  assign cif.prescale = converter_clock_prescale;

  acs_clkdiv u_clkdiv (
    .sys_clk(sys_clk),
    .srst(srst),
    .cif(cif)
  );

  // Conversion sequencing.
  logic tick;
  logic chan_off;
  logic next_ien;
  logic start_tick;
  logic conv_end;
  logic [7:0] sar_next;

  assign tick = cif.tick;
  assign chan_off = (channel_select_field == CH_OFF);
  assign next_ien = wr_status ? pwdata[IEN_BIT] : done_irq_enable;
  assign start_tick = (state == ST_ARMED) & tick;
  assign conv_end = (state == ST_CONV) & tick & (tick_cnt == LAST_TICK);
  // Codes saturate; the sync lag needs a converter clock of sys_clk/4 or slower.
  assign sar_next = sar_step(sar, tick_cnt, comp_sync[1]);

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: next_state = ST_IDLE;
      ST_ARMED: next_state = tick ? ST_CONV : ST_ARMED;
      ST_CONV: begin
        if (conv_end) begin
          next_state = continuous_convert_bit ? ST_ARMED : ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    if (stop_q & ~stop_mode & ~chan_off & continuous_convert_bit) begin
      next_state = ST_ARMED;
    end
    if (wr_status) begin
      next_state = (pwdata[4:0] == CH_OFF) ? ST_IDLE : ST_ARMED;
    end
    if (stop_mode) begin
      next_state = ST_IDLE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state <= ST_IDLE;
      stop_q <= 1'b0;
      tick_cnt <= 4'h0;
      sar <= 8'h0;
      result <= 8'h0;
    end else begin
      state <= next_state;
      stop_q <= stop_mode;
      if (start_tick) begin
        tick_cnt <= 4'h1;
        sar <= 8'h0;
      end else if ((state == ST_CONV) & tick) begin
        tick_cnt <= tick_cnt + 4'h1;
        if (tick_cnt == MSB_TICK) begin
          sar <= SAR_MSB;
        end else if (tick_cnt >= FIRST_BIT_TICK) begin
          sar <= sar_next;
        end
      end
      if (conv_end) begin
        result <= sar_next;
      end
    end
  end

  // Registers written by software; reset clears the enable and flag.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      channel_select_field <= CHAN_RST;
      done_irq_enable <= 1'b0;
      continuous_convert_bit <= 1'b0;
      converter_clock_prescale <= PRESC_RST;
      converter_clock_select_reg <= CLKSEL_RST;
      port_data <= '0;
      port_dir <= '0;
    end else begin
      if (wr_status) begin
        channel_select_field <= pwdata[4:0];
        done_irq_enable <= pwdata[IEN_BIT];
        continuous_convert_bit <= pwdata[CONT_BIT];
      end
      if (wr_clkcfg) begin
        converter_clock_prescale <= pwdata[PRESC_LSB +: 3];
        converter_clock_select_reg <= pwdata[CLKSEL_BIT];
      end
      if (wr_pdata) begin
        port_data <= pwdata[NUM_CH-1:0];
      end
      if (wr_pdir) begin
        port_dir <= pwdata[NUM_CH-1:0];
      end
    end
  end

  // Completion flag and interrupt; a completion in the clearing cycle wins.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      conversion_done_flag <= 1'b0;
      conversion_irq <= 1'b0;
    end else begin
      if (conv_end & ~next_ien) begin
        conversion_done_flag <= 1'b1;
      end else if (wr_status | rd_result) begin
        conversion_done_flag <= 1'b0;
      end
      // The level also serves as the wake request while the core waits.
      if (conv_end & next_ien) begin
        conversion_irq <= 1'b1;
      end else if (wr_status | rd_result | ~done_irq_enable) begin
        conversion_irq <= 1'b0;
      end
    end
  end

  // Pin drivers and analog side outputs.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      port_pin_out <= '0;
      port_pin_oe <= '0;
      selected_analog_input <= CHAN_RST;
      converter_power <= 1'b0;
      dac_code <= 8'h0;
    end else begin
      port_pin_out <= port_data & ~chan_sel;
      port_pin_oe <= port_dir & ~chan_sel;
      selected_analog_input <= channel_select_field;
      converter_power <= ~chan_off & ~stop_mode;
      dac_code <= sar;
    end
  end

  // Helper count of converter clocks seen in the current conversion.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ticks_seen <= 5'h0;
    end else if (start_tick) begin
      ticks_seen <= 5'h1;
    end else if ((state == ST_CONV) & tick) begin
      ticks_seen <= ticks_seen + 5'h1;
    end
  end

  sequence s_end_no_ien;
    conv_end & ~next_ien;
  endsequence
  sequence s_end_ien;
    conv_end & next_ien;
  endsequence

  property p_conv_len;
    @(posedge sys_clk) disable iff (srst) conv_end |-> ticks_seen == 5'd15;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

  property p_start;
    @(posedge sys_clk) disable iff (srst)
      start_tick & ~stop_mode & ~wr_status |=> state == ST_CONV;
  endproperty
  a_start: assert property (p_start) else $error("conversion did not start");

  property p_flag_set;
    @(posedge sys_clk) disable iff (srst) s_end_no_ien |=> conversion_done_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set");

  property p_irq_set;
    @(posedge sys_clk) disable iff (srst) s_end_ien |=> conversion_irq ##1 conversion_irq;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("interrupt not held");

  property p_irq_clear;
    @(posedge sys_clk) disable iff (srst) rd_result & ~conv_end |=> ~conversion_irq;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("interrupt not dropped");

  property p_flag_zero;
    @(posedge sys_clk) disable iff (srst) rd_en & (paddr == ADDR_STATUS) & done_irq_enable
      |-> ~prdata[FLAG_BIT];
  endproperty
  a_flag_zero: assert property (p_flag_zero) else $error("flag visible with ien");

  property p_result;
    @(posedge sys_clk) disable iff (srst) conv_end |=> result == $past(sar_next);
  endproperty
  a_result: assert property (p_result) else $error("result not written");

  property p_pin_free;
    @(posedge sys_clk) disable iff (srst) 1'b1 |=> (port_pin_oe & $past(chan_sel)) == '0;
  endproperty
  a_pin_free: assert property (p_pin_free) else $error("selected pin driven");

  property p_stop;
    @(posedge sys_clk) disable iff (srst) stop_mode |=> (state == ST_IDLE) && !converter_power;
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not abort");

  property p_cont;
    @(posedge sys_clk) disable iff (srst)
      conv_end & continuous_convert_bit & ~wr_status & ~stop_mode |=> state == ST_ARMED;
  endproperty
  a_cont: assert property (p_cont) else $error("continuous mode stopped");
endmodule : acs_top

// ### include/acs_pkg.sv
// Constants and types shared by the converter sequencer files.
package acs_pkg;
  localparam logic [7:0] ADDR_STATUS = 8'h38;
  localparam logic [7:0] ADDR_RESULT = 8'h3C;
  localparam logic [7:0] ADDR_CLKCFG = 8'h40;
  localparam logic [7:0] ADDR_PORT_DATA = 8'h44;
  localparam logic [7:0] ADDR_PORT_DIR = 8'h48;
  localparam logic [7:0] ADDR_PORT_PIN = 8'h4C;
  localparam int NUM_CH = 12;
  localparam logic [4:0] CH_OFF = 5'h1F;
  localparam logic [4:0] CH_REFH = 5'h1D;
  localparam logic [4:0] CH_REFL = 5'h1E;
  localparam int FLAG_BIT = 7;
  localparam int IEN_BIT = 6;
  localparam int CONT_BIT = 5;
  localparam int CLKSEL_BIT = 4;
  localparam int PRESC_LSB = 5;
  localparam logic [4:0] CHAN_RST = 5'h1F;
  localparam logic [2:0] PRESC_RST = 3'h0;
  localparam logic CLKSEL_RST = 1'b0;
  localparam logic [3:0] LAST_TICK = 4'hF;
  localparam logic [3:0] MSB_TICK = 4'h7;
  localparam logic [3:0] FIRST_BIT_TICK = 4'h8;
  localparam logic [7:0] SAR_MSB = 8'h80;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ARMED = 3'b010,
    ST_CONV = 3'b100
  } acs_state_e;
endpackage : acs_pkg

// ### include/acs_conv_if.sv
// Clock source and prescale handed to the converter clock divider.
`timescale 1ns/1ps
interface acs_conv_if;
  logic src_tick;
  logic [2:0] prescale;
  logic tick;
  modport divider(input src_tick, input prescale, output tick);
  modport sequencer(output src_tick, output prescale, input tick);
endinterface : acs_conv_if

// ### rtl/acs_clkdiv.sv
// Divider that makes the converter clock tick from the chosen source.
`timescale 1ns/1ps
module acs_clkdiv
  import acs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  acs_conv_if.divider cif
);
  logic [3:0] cnt;
  logic [3:0] last;
  logic wrap;

  function automatic logic [3:0] div_last(input logic [2:0] presc);
    logic [3:0] r;
    r = 4'hF;
    if (!presc[2]) begin
      case (presc[1:0])
        2'h0: r = 4'h0;
        2'h1: r = 4'h1;
        2'h2: r = 4'h3;
        default: r = 4'h7;
      endcase
    end
    return r;
  endfunction : div_last

  // A prescale change mid-count must not strand the counter above the limit.
  assign last = div_last(cif.prescale);
  assign wrap = (cnt >= last);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cnt <= 4'h0;
      cif.tick <= 1'b0;
    end else begin
      cif.tick <= cif.src_tick & wrap;
      if (cif.src_tick) begin
        cnt <= wrap ? 4'h0 : cnt + 4'h1;
      end
    end
  end
endmodule : acs_clkdiv

// ### tb/acs_analog_model.sv
// Far-side model: analog sources behind the channel pins and the pin wires.
`timescale 1ns/1ps
module acs_analog_model
  import acs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic [4:0] selected_analog_input,
  input wire logic converter_power,
  input wire logic [7:0] dac_code,
  input wire logic signed [9:0] level [NUM_CH],
  input wire logic [NUM_CH-1:0] ext_drive,
  input wire logic [NUM_CH-1:0] port_pin_out,
  input wire logic [NUM_CH-1:0] port_pin_oe,
  output logic comparator_in,
  output logic [NUM_CH-1:0] port_pin_in
);
  logic noise = 1'b0;
  // A dead comparator toggles every cycle, so a stale answer cannot pass for a good one.
  always @(posedge sys_clk) noise <= ~noise;
  always_comb begin
    if (!converter_power) comparator_in = noise;
    else if (selected_analog_input < 5'(NUM_CH))
      comparator_in = level[selected_analog_input[3:0]] >= $signed({2'b00, dac_code});
    else if (selected_analog_input == CH_REFH) comparator_in = 1'b1;
    else if (selected_analog_input == CH_REFL) comparator_in = (dac_code == 8'h00);
    else comparator_in = noise;
  end
  // A pin the device drives shows its own level; otherwise the outside source wins.
  assign port_pin_in = (port_pin_oe & port_pin_out) | (~port_pin_oe & ext_drive);
endmodule : acs_analog_model

// ### tb/tb.sv
// Self-checking bench for the converter sequencer.
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb
  import acs_pkg::*;
;
  logic sys_clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, comparator_in, converter_power, conversion_irq;
  logic stop_mode = 1'b0, crystal_reference_clock = 1'b0;
  logic [NUM_CH-1:0] port_pin_in, port_pin_out, port_pin_oe, ext_drive = 12'hA5C;
  logic [4:0] selected_analog_input;
  logic [7:0] dac_code;
  logic signed [9:0] level [NUM_CH];
  int failures = 0, n_tests = 0, cycles = 0;

  acs_top dut (.sys_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .stop_mode, .crystal_reference_clock, .comparator_in, .port_pin_in,
    .port_pin_out, .port_pin_oe, .selected_analog_input, .converter_power, .dac_code,
    .conversion_irq);
  acs_analog_model far (.sys_clk, .selected_analog_input, .converter_power, .dac_code, .level,
    .ext_drive, .port_pin_out, .port_pin_oe, .comparator_in, .port_pin_in);

  initial begin
    forever #50 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles % 3 == 0) crystal_reference_clock <= ~crystal_reference_clock;
    if (cycles == 20000) begin
      failures++;
      conclude();
    end
  end

  task automatic conclude();
    $display("failures=%0d n_tests=%0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude

  // One whole transfer; two idle edges at the end let registered outputs settle.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask : apb

  task automatic wait_irq(output int n);
    n = 0;
    while (conversion_irq !== 1'b1) begin
      @(posedge sys_clk);
      n++;
    end
  endtask : wait_irq

  task automatic poll_flag();
    do begin
      apb(1'b0, ADDR_STATUS, 32'h0);
    end while (rd[FLAG_BIT] !== 1'b1);
  endtask : poll_flag

  function automatic logic [7:0] expect_code(input logic [4:0] ch);
    if (ch == CH_REFH) return 8'hFF;
    if (ch == CH_REFL) return 8'h00;
    if (level[ch[3:0]] > 255) return 8'hFF;
    if (level[ch[3:0]] < 0) return 8'h00;
    return level[ch[3:0]][7:0];
  endfunction : expect_code

  task automatic t_reset();
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK(rd, 32'h1F)
    `CHK(converter_power, 1'b0)
    apb(1'b0, 8'h50, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
  endtask : t_reset

  task automatic t_timing();
    int n, per;
    // The crystal pin gives one source edge every six sys_clk cycles.
    for (int p = 0; p < 5; p++) begin
      per = 6 * ((p == 4) ? 16 : (1 << p));
      apb(1'b1, ADDR_CLKCFG, 32'(p << 5));
      apb(1'b1, ADDR_STATUS, 32'h40 | 32'(p));
      wait_irq(n);
      `CHK(n >= 15 * per && n <= 17 * per + 6, 1'b1)
      apb(1'b0, ADDR_STATUS, 32'h0);
      `CHK(rd[FLAG_BIT], 1'b0)
      `CHK(conversion_irq, 1'b1)
      apb(1'b0, ADDR_RESULT, 32'h0);
      `CHK(rd, {24'h0, expect_code(5'(p))})
      `CHK(conversion_irq, 1'b0)
    end
    apb(1'b1, ADDR_STATUS, 32'h41);
    wait_irq(n);
    apb(1'b1, ADDR_STATUS, 32'h1F);
    `CHK({conversion_irq, converter_power}, 2'b00)
  endtask : t_timing

  task automatic t_codes();
    logic [4:0] ch;
    // A quarter of the bus rate leaves the comparator sync time to answer.
    apb(1'b1, ADDR_CLKCFG, 32'h50);
    for (int i = 0; i < NUM_CH + 2; i++) begin
      ch = (i < NUM_CH) ? 5'(i) : ((i == NUM_CH) ? CH_REFH : CH_REFL);
      apb(1'b1, ADDR_STATUS, {27'h0, ch});
      `CHK(selected_analog_input, ch)
      poll_flag();
      apb(1'b0, ADDR_RESULT, 32'h0);
      `CHK(rd[7:0], expect_code(ch))
      apb(1'b0, ADDR_STATUS, 32'h0);
      `CHK(rd[FLAG_BIT], 1'b0)
    end
    apb(1'b1, ADDR_STATUS, 32'h06);
    poll_flag();
    apb(1'b1, ADDR_STATUS, 32'h1F);
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK(rd, 32'h1F)
  endtask : t_codes

  task automatic t_cont();
    level[5] = 10'h028;
    apb(1'b1, ADDR_STATUS, 32'h25);
    poll_flag();
    level[5] = 10'h04D;
    // Two hundred cycles hold at least two whole conversions at a quarter rate.
    repeat (200) @(posedge sys_clk);
    apb(1'b0, ADDR_RESULT, 32'h0);
    `CHK(rd[7:0], 8'h4D)
    apb(1'b1, ADDR_STATUS, 32'h05);
    poll_flag();
    level[5] = 10'h009;
    repeat (200) @(posedge sys_clk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK(rd[FLAG_BIT], 1'b1)
    apb(1'b0, ADDR_RESULT, 32'h0);
    `CHK(rd[7:0], 8'h4D)
  endtask : t_cont

  task automatic t_ports();
    apb(1'b1, ADDR_PORT_DIR, 32'h00F);
    apb(1'b1, ADDR_PORT_DATA, 32'h5A5);
    apb(1'b1, ADDR_STATUS, 32'h02);
    `CHK({port_pin_oe, port_pin_out}, {12'h00B, 12'h5A1})
    apb(1'b1, ADDR_PORT_DATA, 32'hFFF);
    `CHK({port_pin_oe, port_pin_out}, {12'h00B, 12'hFFB})
    repeat (4) @(posedge sys_clk);
    apb(1'b0, ADDR_PORT_PIN, 32'h0);
    `CHK(rd[11:0], 12'h00F | (ext_drive & 12'hFF0))
    apb(1'b1, ADDR_PORT_DIR, 32'h00B);
    repeat (4) @(posedge sys_clk);
    apb(1'b0, ADDR_PORT_PIN, 32'h0);
    `CHK(rd[11:0], 12'h00B | (ext_drive & 12'hFF0))
  endtask : t_ports

  task automatic t_stop();
    int n;
    apb(1'b1, ADDR_CLKCFG, 32'h90);
    apb(1'b1, ADDR_STATUS, 32'h63);
    repeat (100) @(posedge sys_clk);
    stop_mode <= 1'b1;
    repeat (400) @(posedge sys_clk);
    `CHK({converter_power, conversion_irq}, 2'b00)
    stop_mode <= 1'b0;
    // Continuous mode picks up again by itself once stop mode ends.
    wait_irq(n);
    `CHK(n >= 15 * 16 && n <= 17 * 16 + 6, 1'b1)
    // The first result after stop is thrown away while the analog side settles.
    apb(1'b0, ADDR_RESULT, 32'h0);
    wait_irq(n);
    apb(1'b0, ADDR_RESULT, 32'h0);
    `CHK(rd[7:0], expect_code(5'h03))
    apb(1'b1, ADDR_STATUS, 32'h1F);
    apb(1'b1, ADDR_CLKCFG, 32'h00);
    apb(1'b1, ADDR_STATUS, 32'h43);
    wait_irq(n);
    apb(1'b0, ADDR_RESULT, 32'h0);
    `CHK(rd[7:0], expect_code(5'h03))
  endtask : t_stop

  initial begin
    for (int i = 0; i < NUM_CH; i++) level[i] = 10'(20 * i + 7);
    level[10] = 10'h12C;
    level[11] = -10'sh005;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_timing();
    t_codes();
    t_cont();
    t_ports();
    t_stop();
    conclude();
  end
endmodule : tb
